// ==== core/ciee_defines.svh ====
`ifndef CIEE_DEFINES_SVH
`define CIEE_DEFINES_SVH

// Vector map
`define CIEE_VEC_RESET 16'hFFFE
`define CIEE_VEC_SWI 16'hFFFC
`define CIEE_VEC_IRQ0 16'hFFFA
`define CIEE_NUM_VECTORS 128
`define CIEE_NUM_HW_IRQ 126

// Condition code layout: mask bit position and reset value
`define CIEE_CCR_MASK_BIT 3
`define CIEE_CCR_RESET 8'h08
`define CIEE_SP_RESET 16'h00FF

// Number of bytes stacked on entry
`define CIEE_STACK_BYTES 5

`endif

// ==== core/ciee_pkg.sv ====
package ciee_pkg;

    typedef enum {
        CIEE_RUN,
        CIEE_PUSH,
        CIEE_VEC_HI,
        CIEE_VEC_LO,
        CIEE_PULL,
        CIEE_WAIT
    } ciee_state_e;

    typedef struct packed {
        logic [7:0] condition_code_reg;
        logic [7:0] acc;
        logic [7:0] idx_lo;
        logic [15:0] pc;
    } ciee_regs_s;

    typedef struct packed {
        logic valid;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ciee_mem_s;

endpackage : ciee_pkg

// ==== core/ciee_vector_gen.sv ====
`timescale 1ns/10ps
`include "ciee_defines.svh"

module ciee_vector_gen
    import ciee_pkg::*;
#(
    parameter int NUM_IRQ = `CIEE_NUM_HW_IRQ
) (
    input wire logic is_swi_i,
    input wire logic [6:0] irq_code_i,
    output logic [15:0] vec_addr_o
);

    initial begin
        if (NUM_IRQ < 1 || NUM_IRQ > `CIEE_NUM_HW_IRQ) begin
            $error("NUM_IRQ out of range");
        end
    end

    logic [15:0] irq_vec;

    assign irq_vec = `CIEE_VEC_IRQ0 - {8'h00, irq_code_i, 1'b0};
    assign vec_addr_o = is_swi_i ? `CIEE_VEC_SWI : irq_vec;

endmodule : ciee_vector_gen

// ==== core/ciee_entry_exit.sv ====
`timescale 1ns/10ps
`include "ciee_defines.svh"

// Summary of operation
// - take interrupt after current instruction completes
// - stack all registers except index high
// - load winning vector then run handler
// - return op restores registers and address
// - need clear mask and local enable
// - entry sets global mask bit
// - return restores stacked mask value
// - reset sets mask; clear op clears, transfer copies bit 3
// - 128 vectors, 126 hardware sources
// - vectors descend two bytes from FFFE
// - start only at instruction boundary, or on wake from wait/stop
// - software trap outranks all but reset
// - wait mode wakes on enabled interrupt
// - stop mode accepts asynchronous wake
// - service highest, others stay pending
// - cleared mask re-takes still-flagged source
// - stack adjust adds sign-extended immediate
// - stack pointer addresses next empty slot
// - mask change effective before next boundary
// - return applies mask in third pull cycle
module ciee_entry_exit
    import ciee_pkg::*;
#(
    parameter int NUM_IRQ = `CIEE_NUM_HW_IRQ
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic insn_boundary_i,
    input wire logic irq_pending_i,
    input wire logic irq_local_en_i,
    input wire logic [6:0] irq_code_i,
    input wire logic swi_fetch_i,
    input wire logic rti_op_i,
    input wire logic clear_mask_op_i,
    input wire logic set_mask_op_i,
    input wire logic tap_op_i,
    input wire logic [7:0] tap_value_i,
    input wire logic stack_adjust_op_i,
    input wire logic [7:0] stack_adjust_imm_i,
    input wire logic wait_op_i,
    input wire logic stop_op_i,
    input wire logic async_wake_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] idx_lo_i,
    input wire logic [7:0] ccr_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] mem_rdata_i,
    output logic [15:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    output logic mem_valid_o,
    output logic mem_we_o,
    output logic [15:0] sp_o,
    output logic mask_o,
    output logic [7:0] ccr_o,
    output logic [7:0] acc_o,
    output logic [7:0] idx_lo_o,
    output logic [15:0] pc_o,
    output logic regs_load_o,
    output logic irq_ack_o,
    output logic core_clk_en_o,
    output logic sys_clk_en_o,
    output logic busy_o
);

    initial begin
        if (NUM_IRQ < 1 || NUM_IRQ > `CIEE_NUM_HW_IRQ) begin
            $error("NUM_IRQ out of range");
        end
    end

    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    logic rst_n;
    assign rst_n = rst_s2_q;

    ciee_state_e state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [15:0] sp_q, sp_d;
    logic mask_q, mask_d;
    logic swi_q, swi_d;
    logic stop_q, stop_d;
    logic [15:0] vec_q, vec_d;
    ciee_regs_s save_q, save_d;
    ciee_mem_s mem_q, mem_d;
    logic load_q, load_d;
    logic ack_q, ack_d;
    logic [15:0] pc_new_q, pc_new_d;
    logic [7:0] ccr_new_q, ccr_new_d;
    logic [7:0] acc_new_q, acc_new_d;
    logic [7:0] x_new_q, x_new_d;
    logic [15:0] vec_addr;
    logic wake_sync1_q, wake_sync2_q;

    // Stop wake level is asynchronous; two-flop synchroniser
    // synchronise asynchronous wake
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wake_sync1_q <= 1'b0;
            wake_sync2_q <= 1'b0;
        end else begin
            wake_sync1_q <= async_wake_i;
            wake_sync2_q <= wake_sync1_q;
        end
    end

    function automatic logic [7:0] stack_byte(input ciee_regs_s r, input logic [2:0] idx);
        logic [7:0] b;
        b = 8'h00;
        case (idx)
            3'd0: b = r.pc[7:0];
            3'd1: b = r.pc[15:8];
            3'd2: b = r.idx_lo;
            3'd3: b = r.acc;
            3'd4: b = r.condition_code_reg;
            default: b = 8'h00;
        endcase
        return b;
    endfunction : stack_byte

    // global and local enable both needed
    logic irq_take;
    assign irq_take = irq_pending_i && irq_local_en_i && !mask_q;

    logic at_boundary;
    // only once the instruction has finished
    assign at_boundary = insn_boundary_i && state_q == CIEE_RUN;

    logic [15:0] sp_adjust;
    assign sp_adjust = sp_q + {{8{stack_adjust_imm_i[7]}}, stack_adjust_imm_i};

    ciee_vector_gen #(
        .NUM_IRQ(NUM_IRQ)
    ) u_vector_gen (
        .is_swi_i(swi_q),
        .irq_code_i(irq_code_i),
        .vec_addr_o(vec_addr)
    );

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        sp_d = sp_q;
        mask_d = mask_q;
        swi_d = swi_q;
        stop_d = stop_q;
        vec_d = vec_q;
        save_d = save_q;
        mem_d = '0;
        load_d = 1'b0;
        ack_d = 1'b0;
        pc_new_d = pc_new_q;
        ccr_new_d = ccr_new_q;
        acc_new_d = acc_new_q;
        x_new_d = x_new_q;
        case (state_q)
            CIEE_RUN: begin
                // mask change seen at next boundary
                if (clear_mask_op_i) begin
                    mask_d = 1'b0;
                end else if (set_mask_op_i) begin
                    mask_d = 1'b1;
                end else if (tap_op_i) begin
                    mask_d = tap_value_i[`CIEE_CCR_MASK_BIT];
                end
                if (stack_adjust_op_i) begin
                    sp_d = sp_adjust;
                end
                if (swi_fetch_i) begin
                    swi_d = 1'b1;
                end
                if (at_boundary && (swi_q || swi_fetch_i || irq_take)) begin
                    save_d.pc = pc_i;
                    save_d.acc = acc_i;
                    save_d.idx_lo = idx_lo_i;
                    save_d.condition_code_reg = ccr_i;
                    cnt_d = 4'd0;
                    mask_d = 1'b1;
                    ack_d = !(swi_q || swi_fetch_i);
                    state_d = CIEE_PUSH;
                end else if (at_boundary && rti_op_i) begin
                    cnt_d = 4'd0;
                    state_d = CIEE_PULL;
                end else if (at_boundary && (wait_op_i || stop_op_i)) begin
                    // Wait and stop both open the mask
                    mask_d = 1'b0;
                    stop_d = stop_op_i;
                    state_d = CIEE_WAIT;
                end
            end
            CIEE_PUSH: begin
                mem_d.valid = 1'b1;
                mem_d.we = 1'b1;
                mem_d.addr = sp_q;
                mem_d.wdata = stack_byte(save_q, cnt_q[2:0]);
                sp_d = sp_q - 16'h0001;
                cnt_d = cnt_q + 4'd1;
                if (cnt_q == 4'(`CIEE_STACK_BYTES - 1)) begin
                    vec_d = vec_addr;
                    state_d = CIEE_VEC_HI;
                end
            end
            CIEE_VEC_HI: begin
                mem_d.valid = 1'b1;
                mem_d.addr = vec_q;
                state_d = CIEE_VEC_LO;
            end
            CIEE_VEC_LO: begin
                mem_d.valid = 1'b1;
                mem_d.addr = vec_q + 16'h0001;
                state_d = CIEE_PULL;
                cnt_d = 4'd8;
            end
            CIEE_PULL: begin
                // Read data lags its request by two cycles
                cnt_d = cnt_q + 4'd1;
                // pull ccr, a, x, pch, pcl
                if (cnt_q < 4'(`CIEE_STACK_BYTES)) begin
                    mem_d.valid = 1'b1;
                    mem_d.addr = sp_q + 16'h0001;
                    sp_d = sp_q + 16'h0001;
                end
                case (cnt_q)
                    4'd2: ccr_new_d = mem_rdata_i;
                    4'd3: acc_new_d = mem_rdata_i;
                    4'd4: x_new_d = mem_rdata_i;
                    4'd5: pc_new_d[15:8] = mem_rdata_i;
                    4'd6: pc_new_d[7:0] = mem_rdata_i;
                    4'd8: pc_new_d[15:8] = mem_rdata_i;
                    4'd9: pc_new_d[7:0] = mem_rdata_i;
                    default: ;
                endcase
                // applied as soon as ccr arrives
                if (cnt_q == 4'd2) begin
                    mask_d = mem_rdata_i[`CIEE_CCR_MASK_BIT];
                end
                if (cnt_q == 4'd9) begin
                    ccr_new_d = save_q.condition_code_reg | `CIEE_CCR_RESET;
                    acc_new_d = save_q.acc;
                    x_new_d = save_q.idx_lo;
                    // pending trap cleared on vector fetch
                    swi_d = 1'b0;
                end
                if (cnt_q == 4'd6 || cnt_q == 4'd9) begin
                    // re-entry falls out of RUN check
                    load_d = 1'b1;
                    state_d = CIEE_RUN;
                end
            end
            CIEE_WAIT: begin
                // enabled interrupt wakes straight into entry
                if (irq_take && (!stop_q || wake_sync2_q)) begin
                    save_d.pc = pc_i;
                    save_d.acc = acc_i;
                    save_d.idx_lo = idx_lo_i;
                    save_d.condition_code_reg = ccr_i;
                    cnt_d = 4'd0;
                    mask_d = 1'b1;
                    ack_d = 1'b1;
                    stop_d = 1'b0;
                    state_d = CIEE_PUSH;
                end
            end
            default: state_d = CIEE_RUN;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= CIEE_RUN;
            cnt_q <= 4'd0;
            sp_q <= `CIEE_SP_RESET;
            mask_q <= 1'b1;
            swi_q <= 1'b0;
            stop_q <= 1'b0;
            vec_q <= `CIEE_VEC_RESET;
            save_q <= '0;
            mem_q <= '0;
            load_q <= 1'b0;
            ack_q <= 1'b0;
            pc_new_q <= '0;
            ccr_new_q <= `CIEE_CCR_RESET;
            acc_new_q <= '0;
            x_new_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sp_q <= sp_d;
            mask_q <= mask_d;
            swi_q <= swi_d;
            stop_q <= stop_d;
            vec_q <= vec_d;
            save_q <= save_d;
            mem_q <= mem_d;
            load_q <= load_d;
            ack_q <= ack_d;
            pc_new_q <= pc_new_d;
            ccr_new_q <= ccr_new_d;
            acc_new_q <= acc_new_d;
            x_new_q <= x_new_d;
        end
    end

    logic clk_run_q, sys_run_q, busy_q;
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            clk_run_q <= 1'b1;
            sys_run_q <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            clk_run_q <= state_d != CIEE_WAIT;
            sys_run_q <= !(state_d == CIEE_WAIT && stop_d);
            busy_q <= state_d != CIEE_RUN && state_d != CIEE_WAIT;
        end
    end

    assign mem_addr_o = mem_q.addr;
    assign mem_wdata_o = mem_q.wdata;
    assign mem_valid_o = mem_q.valid;
    assign mem_we_o = mem_q.we;
    assign sp_o = sp_q;
    assign mask_o = mask_q;
    assign ccr_o = ccr_new_q;
    assign acc_o = acc_new_q;
    assign idx_lo_o = x_new_q;
    assign pc_o = pc_new_q;
    assign regs_load_o = load_q;
    assign irq_ack_o = ack_q;
    assign core_clk_en_o = clk_run_q;
    assign sys_clk_en_o = sys_run_q;
    assign busy_o = busy_q;

endmodule : ciee_entry_exit

// ==== verif/ciee_entry_exit_sva.sv ====
`timescale 1ns/10ps

module ciee_entry_exit_sva
    import ciee_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic insn_boundary_i,
    input wire logic irq_pending_i,
    input wire logic irq_local_en_i,
    input wire logic [6:0] irq_code_i,
    input wire logic swi_fetch_i,
    input wire logic rti_op_i,
    input wire logic clear_mask_op_i,
    input wire logic stack_adjust_op_i,
    input wire logic [7:0] stack_adjust_imm_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic [15:0] mem_addr_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic mem_valid_o,
    input wire logic mem_we_o,
    input wire logic [15:0] sp_o,
    input wire logic mask_o,
    input wire logic [7:0] ccr_o,
    input wire logic regs_load_o,
    input wire logic irq_ack_o,
    input wire logic core_clk_en_o,
    input wire logic busy_o
);
    logic swi_q;
    logic [15:0] vec_q;

    // Expected vector latched where the entry is taken
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            swi_q <= 1'b0;
            vec_q <= 16'h0000;
        end else begin
            swi_q <= swi_fetch_i || (swi_q && !regs_load_o);
            if ((insn_boundary_i || !core_clk_en_o) && !busy_o) begin
                vec_q <= (swi_q || swi_fetch_i) ? 16'hFFFC
                                                : 16'hFFFA - {8'h00, irq_code_i, 1'b0};
            end
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    chk_take_acked: assert property (
        insn_boundary_i && irq_pending_i && irq_local_en_i && !mask_o && !busy_o
        && core_clk_en_o && !swi_q && !swi_fetch_i |=> irq_ack_o)
        else $error("entry not acknowledged");
    chk_ack_boundary: assert property (
        irq_ack_o |-> $past(insn_boundary_i) || !$past(core_clk_en_o))
        else $error("entry outside a boundary");
    chk_entry_mask: assert property (
        irq_ack_o |-> ##9 regs_load_o && ccr_o[3] && mask_o) else $error("entry mask");
    chk_push_order: assert property (
        irq_ack_o |=> mem_we_o && mem_wdata_o == $past(pc_i[7:0], 2)
        ##1 mem_wdata_o == $past(pc_i[15:8], 3)) else $error("push order");
    chk_push_down: assert property (
        irq_ack_o |=> mem_valid_o ##1 (mem_addr_o == $past(mem_addr_o) - 16'h0001)[*4])
        else $error("push address");
    chk_vector_addr: assert property (
        irq_ack_o |-> ##6 mem_valid_o && !mem_we_o && mem_addr_o == vec_q
        ##1 mem_addr_o == vec_q + 16'h0001) else $error("vector address");
    chk_return_mask: assert property (
        rti_op_i && insn_boundary_i && !busy_o && core_clk_en_o
        |-> ##2 mem_addr_o == $past(sp_o) + 16'h0001
        ##2 mask_o == $past(mem_rdata_i[3]) ##4 regs_load_o) else $error("return");
    chk_clear_mask: assert property (
        clear_mask_op_i && !busy_o |=> !mask_o) else $error("clear mask");
    chk_sp_adjust: assert property (
        stack_adjust_op_i && !busy_o |=> sp_o == $past(sp_o)
        + 16'($signed($past(stack_adjust_imm_i)))) else $error("stack adjust");
    chk_wait_wake: assert property (
        !core_clk_en_o && irq_pending_i && irq_local_en_i |-> ##[1:4] irq_ack_o)
        else $error("no wake");
endmodule : ciee_entry_exit_sva

bind ciee_entry_exit ciee_entry_exit_sva chk_inst (.clk_i, .rst_b_i, .insn_boundary_i,
    .irq_pending_i, .irq_local_en_i, .irq_code_i, .swi_fetch_i, .rti_op_i, .clear_mask_op_i,
    .stack_adjust_op_i, .stack_adjust_imm_i, .pc_i, .mem_rdata_i, .mem_addr_o, .mem_wdata_o,
    .mem_valid_o, .mem_we_o, .sp_o, .mask_o, .ccr_o, .regs_load_o, .irq_ack_o,
    .core_clk_en_o, .busy_o);

// ==== verif/ciee_mem_model.sv ====
`timescale 1ns/10ps

module ciee_mem_model (
    input wire logic clk_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [7:0] mem_wdata_i,
    input wire logic mem_valid_i,
    input wire logic mem_we_i,
    output logic [7:0] rdata_o
);
    logic [7:0] ram [0:255];
    logic [7:0] rd_d;
    assign rd_d = (mem_addr_i[15:8] != 8'hFF) ? ram[mem_addr_i[7:0]]
                : mem_addr_i[0] ? {mem_addr_i[7:1], 1'b0} : 8'hC0;
    initial rdata_o = 8'h5A;
    // Idle data toggles so a stale byte never passes
    always @(posedge clk_i) begin
        if (mem_valid_i && mem_we_i) begin
            ram[mem_addr_i[7:0]] <= mem_wdata_i;
        end
        rdata_o <= (mem_valid_i && !mem_we_i) ? rd_d : ~rdata_o;
    end
endmodule : ciee_mem_model

// ==== verif/ciee_entry_exit_tb.sv ====
`timescale 1ns/10ps

module ciee_entry_exit_tb
    import ciee_pkg::*;
;
    logic clk_i = 1'b0, rst_b_i = 1'b0, insn_boundary_i = 1'b0, irq_pending_i = 1'b0;
    logic irq_local_en_i = 1'b1, swi_fetch_i = 1'b0, rti_op_i = 1'b0, clear_mask_op_i = 1'b0;
    logic set_mask_op_i = 1'b0, tap_op_i = 1'b0, stack_adjust_op_i = 1'b0, wait_op_i = 1'b0;
    logic stop_op_i = 1'b0, async_wake_i = 1'b0;
    logic [6:0] irq_code_i = 7'h00;
    logic [7:0] tap_value_i = 8'h00, stack_adjust_imm_i = 8'h00, acc_i = 8'hA5;
    logic [7:0] idx_lo_i = 8'h3C, ccr_i = 8'h01, mem_rdata_i;
    logic [15:0] pc_i = 16'h1234, mem_addr_o, sp_o, pc_o;
    logic [7:0] mem_wdata_o, ccr_o, acc_o, idx_lo_o;
    logic mem_valid_o, mem_we_o, mask_o, regs_load_o, irq_ack_o, core_clk_en_o;
    logic sys_clk_en_o, busy_o;
    logic [15:0] vec;
    logic [7:0] top;
    logic [7:0] stk [5];
    int n_errors = 0, compares = 0, cyc = 0;

    ciee_entry_exit ciee_entry_exit_inst (.clk_i, .rst_b_i, .insn_boundary_i, .irq_pending_i,
        .irq_local_en_i, .irq_code_i, .swi_fetch_i, .rti_op_i, .clear_mask_op_i,
        .set_mask_op_i, .tap_op_i, .tap_value_i, .stack_adjust_op_i, .stack_adjust_imm_i,
        .wait_op_i, .stop_op_i, .async_wake_i, .acc_i, .idx_lo_i, .ccr_i, .pc_i,
        .mem_rdata_i, .mem_addr_o, .mem_wdata_o, .mem_valid_o, .mem_we_o, .sp_o, .mask_o,
        .ccr_o, .acc_o, .idx_lo_o, .pc_o, .regs_load_o, .irq_ack_o, .core_clk_en_o,
        .sys_clk_en_o, .busy_o);
    ciee_mem_model ciee_mem_model_inst (.clk_i, .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .mem_valid_i(mem_valid_o), .mem_we_i(mem_we_o),
        .rdata_o(mem_rdata_i));

    always #5 clk_i = ~clk_i;

    task automatic wrap_up();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    // Hang guard, tests need under two hundred cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask : step

    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask : pulse

    // Op presented with the boundary, then wait for the register load
    task automatic at_bnd(ref logic s, input bit ld);
        int k;
        s = 1'b1;
        insn_boundary_i = 1'b1;
        step(1);
        s = 1'b0;
        insn_boundary_i = 1'b0;
        k = 0;
        while (ld && regs_load_o !== 1'b1 && k < 30) begin
            step(1);
            k++;
        end
        if (ld) chk({15'h0000, regs_load_o}, 16'h0001);
    endtask : at_bnd

    initial begin
        step(10);
        rst_b_i = 1'b1;
        step(3);
        chk(sp_o, 16'h00FF);
        chk({mask_o, ccr_o}, 16'h0108);
        $display("test reset done");
        irq_pending_i = 1'b1;
        insn_boundary_i = 1'b1;
        step(3);
        chk({15'h0000, busy_o}, 16'h0000);
        pulse(clear_mask_op_i);
        irq_local_en_i = 1'b0;
        step(3);
        chk({15'h0000, busy_o}, 16'h0000);
        irq_pending_i = 1'b0;
        insn_boundary_i = 1'b0;
        irq_local_en_i = 1'b1;
        $display("test masked done");
        for (int i = 0; i < 2; i++) begin
            irq_code_i = i ? 7'd125 : 7'd0;
            vec = 16'hFFFA - {8'h00, irq_code_i, 1'b0};
            pc_i = 16'h1234 + 16'(i);
            pulse(clear_mask_op_i);
            at_bnd(irq_pending_i, 1'b1);
            chk(pc_o, {8'hC0, vec[7:0]});
            chk({8'h00, ccr_o}, 16'h0009);
            chk(sp_o, 16'h00FA - 16'(5 * i));
            stk = '{pc_i[7:0], pc_i[15:8], idx_lo_i, acc_i, ccr_i};
            top = 8'hFF - 8'(5 * i);
            for (int j = 0; j < 5; j++) begin
                chk({8'h00, ciee_mem_model_inst.ram[top - 8'(j)]}, {8'h00, stk[j]});
            end
        end
        $display("test entry done");
        for (int i = 1; i >= 0; i--) begin
            if (i == 0) ciee_mem_model_inst.ram[8'hFB] = 8'h09;
            at_bnd(rti_op_i, 1'b1);
            chk(pc_o, 16'h1234 + 16'(i));
            chk({acc_o, idx_lo_o}, 16'hA53C);
            chk({7'h00, mask_o, ccr_o}, (i == 0) ? 16'h0109 : 16'h0001);
            chk(sp_o, 16'h00FF - 16'(5 * i));
        end
        $display("test return done");
        pulse(clear_mask_op_i);
        pulse(swi_fetch_i);
        irq_code_i = 7'd3;
        at_bnd(irq_pending_i, 1'b1);
        chk(pc_o, 16'hC0FC);
        $display("test trap done");
        stack_adjust_imm_i = 8'hF0;
        pulse(stack_adjust_op_i);
        step(1);
        chk(sp_o, 16'h00EA);
        stack_adjust_imm_i = 8'h10;
        pulse(stack_adjust_op_i);
        step(1);
        chk(sp_o, 16'h00FA);
        pulse(tap_op_i);
        step(1);
        chk({15'h0000, mask_o}, 16'h0000);
        pulse(set_mask_op_i);
        step(1);
        chk({15'h0000, mask_o}, 16'h0001);
        $display("test ops done");
        at_bnd(wait_op_i, 1'b0);
        step(2);
        chk({15'h0000, core_clk_en_o}, 16'h0000);
        irq_code_i = 7'd9;
        irq_pending_i = 1'b1;
        at_bnd(async_wake_i, 1'b1);
        irq_pending_i = 1'b0;
        chk({core_clk_en_o, pc_o[14:0]}, 16'hC0E8);
        at_bnd(stop_op_i, 1'b0);
        step(2);
        chk({15'h0000, sys_clk_en_o}, 16'h0000);
        // wake needs an enabled request as well
        irq_pending_i = 1'b1;
        async_wake_i = 1'b1;
        step(6);
        async_wake_i = 1'b0;
        irq_pending_i = 1'b0;
        chk({15'h0000, sys_clk_en_o}, 16'h0001);
        $display("test low power done");
        wrap_up();
    end
endmodule : ciee_entry_exit_tb
